/* mps_regs.vh */
// Register map, field positions and constants for the pin, port and strobe block.
// Assumes a 32-bit APB master; each register occupies one aligned word.
`ifndef MPS_REGS_VH
`define MPS_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MPS_P1_DIR_OFS 8'h00
`define MPS_P2_DIR_OFS 8'h04
`define MPS_P1_DATA_OFS 8'h08
`define MPS_P2_DATA_OFS 8'h0C
`define MPS_P3_DIR_OFS 8'h10
`define MPS_P3_DATA_OFS 8'h18
`define MPS_P3_CTRL_OFS 8'h3C
`define MPS_CPU_OFS 8'h40
`define MPS_IRQ_STAT_OFS 8'h44
`define MPS_IRQ_MASK_OFS 8'h48
`define MPS_MODE_OFS 8'h4C
`define MPS_VEC_OFS 8'h50
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MPS_P3C_FLAG 7
`define MPS_P3C_IRQ_EN 6
`define MPS_P3C_OSS 4
`define MPS_P3C_LATCH 3
`define MPS_CPU_IMASK 0
`define MPS_CPU_DONE 1
`define MPS_ST_NMI 0
`define MPS_ST_MASKABLE_REQUEST_ONE 1
`define MPS_ST_IS3 2
`define MPS_ST_W 3
// ----------------------------------------------------------------
// Vectors, modes, address window, counts
// ----------------------------------------------------------------
`define MPS_VEC_NMI 16'hFFFC
`define MPS_VEC_MASKABLE_REQUEST_ONE 16'hFFF8
`define MPS_IOS_LO 16'h0100
`define MPS_IOS_HI 16'h01FF
`define MPS_MODE_SINGLE 3'h7
`define MPS_MODE_MUX_A 3'h2
`define MPS_MODE_MUX_B 3'h3
`define MPS_MODE_NONMUX 3'h5
`define MPS_ECLK_DIV 2'h3
`define MPS_ECLK_HALF 2'h1
`define MPS_RESET_E_MIN 3

`endif

/* mps_pins.v */
// Pin-level control logic: E clock, NMI/MASKABLE_REQUEST_ONE entry, strobe pins, ports 1-3.
// Assumes one 25 MHz clock, synchronous active-high reset and an APB master.
`timescale 1ns/100ps
`default_nettype none
`include "mps_regs.vh"

module mps_pins #(
  parameter P1_W = 8,
  parameter P2_W = 5,
  parameter P3_W = 8
) (
  input wire clock_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output reg irq_o,
  output reg eclk_o,
  input wire nmi_n_i,
  input wire maskable_request_one_n_i,
  input wire instr_done_i,
  input wire [15:0] cpu_addr_i,
  input wire cpu_rw_i,
  input wire compare_out_i,
  output reg vec_fetch_o,
  output reg [15:0] vec_addr_o,
  input wire strobe_ctrl_pin_a_i,
  output reg strobe_ctrl_pin_a_o,
  output reg strobe_ctrl_pin_a_oe_o,
  output reg strobe_ctrl_pin_b_o,
  input wire [P1_W-1:0] port1_i,
  output reg [P1_W-1:0] port1_o,
  output reg [P1_W-1:0] port1_oe_o,
  input wire [P2_W-1:0] port2_i,
  output reg [P2_W-1:0] port2_o,
  output reg [P2_W-1:0] port2_oe_o,
  input wire [P3_W-1:0] port3_i,
  output reg [P3_W-1:0] port3_o,
  output reg [P3_W-1:0] port3_oe_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Per-line drive: direction bit one drives the data bit
  function [7:0] mps_drive;
    input [7:0] dir;
    input [7:0] dat;
    begin
      mps_drive = dir & dat;
    end
  endfunction

  function mps_expanded;
    input [2:0] m;
    begin
      mps_expanded = (m != `MPS_MODE_SINGLE);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0] div_reg;
  reg e_tick_reg;
  reg [2:0] mode_reg;
  reg reset_d_reg;
  reg [P1_W-1:0] p1_dir_reg;
  reg [P1_W-1:0] p1_dat_reg;
  reg [P2_W-1:0] p2_dir_reg;
  reg [P2_W-1:0] p2_dat_reg;
  reg [P3_W-1:0] p3_dir_reg;
  reg [P3_W-1:0] p3_dat_reg;
  reg [P3_W-1:0] p3_latch_reg;
  reg p3_flag_reg;
  reg p3_irq_en_reg;
  reg p3_oss_reg;
  reg p3_latch_en_reg;
  reg p3_latched_reg;
  reg imask_reg;
  reg nmi_pend_reg;
  reg nmi_d_reg;
  reg is3_d_reg;
  reg [`MPS_ST_W-1:0] stat_reg;
  reg [`MPS_ST_W-1:0] mask_reg;
  reg os3_req_reg;
  reg [1:0] state_reg;

  localparam ST_RUN = 2'b00;
  localparam ST_NMI = 2'b01;
  localparam ST_IRQ = 2'b10;

  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire rd = acc & ~pwrite_i;
  wire single = (mode_reg == `MPS_MODE_SINGLE);
  wire muxed = (mode_reg == `MPS_MODE_MUX_A) || (mode_reg == `MPS_MODE_MUX_B);
  wire nmi_fall = nmi_d_reg & ~nmi_n_i;
  wire is3_fall = single & is3_d_reg & ~strobe_ctrl_pin_a_i;
  wire maskable_request_one_level = ~maskable_request_one_n_i | (p3_flag_reg & p3_irq_en_reg);
  wire p3_hit = (paddr_i == `MPS_P3_DATA_OFS);

  // ----------------------------------------------------------------
  // E clock divider
  // ----------------------------------------------------------------
  // Divide by four; e_tick marks each E period, though nothing reads it
  always @(posedge clock_i) begin
    if (reset_i) begin
      div_reg <= 2'h0;
      eclk_o <= 1'b0;
      e_tick_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      eclk_o <= (div_reg >= `MPS_ECLK_HALF) && (div_reg != `MPS_ECLK_DIV);
      e_tick_reg <= (div_reg == `MPS_ECLK_DIV);
    end
  end

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  // Caught one clock after release, never under reset itself.
  // Relies on the reset source keeping reset long enough.
  always @(posedge clock_i) begin
    reset_d_reg <= reset_i;
    if (reset_i) begin
      mode_reg <= `MPS_MODE_SINGLE;
    end else if (reset_d_reg) begin
      mode_reg <= port2_i[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt entry
  // ----------------------------------------------------------------
  // NMI edge is held pending until the instruction ends; a low shorter
  // than one E cycle may still be seen, but is not promised.
  always @(posedge clock_i) begin
    if (reset_i) begin
      nmi_d_reg <= 1'b1;
      nmi_pend_reg <= 1'b0;
      state_reg <= ST_RUN;
      vec_fetch_o <= 1'b0;
      vec_addr_o <= 16'h0000;
      imask_reg <= 1'b1;
    end else begin
      nmi_d_reg <= nmi_n_i;
      vec_fetch_o <= 1'b0;
      if (nmi_fall) begin
        nmi_pend_reg <= 1'b1;
      end
      if (wr && paddr_i == `MPS_CPU_OFS) begin
        imask_reg <= pwdata_i[`MPS_CPU_IMASK];
      end
      case (state_reg)
        ST_RUN: begin
          if (instr_done_i && (nmi_pend_reg || nmi_fall)) begin
            state_reg <= ST_NMI;
          end else if (instr_done_i && maskable_request_one_level && !imask_reg) begin
            state_reg <= ST_IRQ;
          end
        end
        ST_NMI: begin
          nmi_pend_reg <= nmi_fall;
          vec_fetch_o <= 1'b1;
          vec_addr_o <= `MPS_VEC_NMI;
          imask_reg <= 1'b1;
          state_reg <= ST_RUN;
        end
        ST_IRQ: begin
          vec_fetch_o <= 1'b1;
          vec_addr_o <= `MPS_VEC_MASKABLE_REQUEST_ONE;
          imask_reg <= 1'b1;
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Port registers and port 3 control
  // ----------------------------------------------------------------
  // Set wins over a same-cycle clear for the input strobe flag
  always @(posedge clock_i) begin
    if (reset_i) begin
      p1_dir_reg <= {P1_W{1'b0}};
      p1_dat_reg <= {P1_W{1'b0}};
      p2_dir_reg <= {P2_W{1'b0}};
      p2_dat_reg <= {P2_W{1'b0}};
      p3_dir_reg <= {P3_W{1'b0}};
      p3_dat_reg <= {P3_W{1'b0}};
      p3_latch_reg <= {P3_W{1'b0}};
      p3_flag_reg <= 1'b0;
      p3_irq_en_reg <= 1'b0;
      p3_oss_reg <= 1'b0;
      p3_latch_en_reg <= 1'b0;
      p3_latched_reg <= 1'b0;
      is3_d_reg <= 1'b1;
      os3_req_reg <= 1'b0;
    end else begin
      is3_d_reg <= strobe_ctrl_pin_a_i;
      if (wr) begin
        case (paddr_i)
          `MPS_P1_DIR_OFS: p1_dir_reg <= pwdata_i[P1_W-1:0];
          `MPS_P1_DATA_OFS: p1_dat_reg <= pwdata_i[P1_W-1:0];
          `MPS_P2_DIR_OFS: p2_dir_reg <= pwdata_i[P2_W-1:0];
          `MPS_P2_DATA_OFS: p2_dat_reg <= pwdata_i[P2_W-1:0];
          `MPS_P3_DIR_OFS: p3_dir_reg <= pwdata_i[P3_W-1:0];
          `MPS_P3_DATA_OFS: p3_dat_reg <= pwdata_i[P3_W-1:0];
          `MPS_P3_CTRL_OFS: begin
            p3_irq_en_reg <= pwdata_i[`MPS_P3C_IRQ_EN];
            p3_oss_reg <= pwdata_i[`MPS_P3C_OSS];
            p3_latch_en_reg <= pwdata_i[`MPS_P3C_LATCH];
          end
          default: begin
          end
        endcase
      end
      // Flag clears on any port 3 data access, read or write; set wins
      if (is3_fall) begin
        p3_flag_reg <= 1'b1;
      end else if (acc && p3_hit) begin
        p3_flag_reg <= 1'b0;
      end
      // Input latch freezes on strobe until data is read
      if (is3_fall && p3_latch_en_reg && !p3_latched_reg) begin
        p3_latch_reg <= port3_i;
        p3_latched_reg <= 1'b1;
      end else if (rd && p3_hit) begin
        p3_latched_reg <= 1'b0;
      end
      // Output strobe on read when select is 0, write when 1
      os3_req_reg <= single & acc & p3_hit & (pwrite_i == p3_oss_reg);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Write one clears; a new event in the same cycle wins
  always @(posedge clock_i) begin
    if (reset_i) begin
      stat_reg <= {`MPS_ST_W{1'b0}};
      mask_reg <= {`MPS_ST_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~((wr && paddr_i == `MPS_IRQ_STAT_OFS) ? pwdata_i[`MPS_ST_W-1:0] :
        {`MPS_ST_W{1'b0}})) | {is3_fall, ~maskable_request_one_n_i, nmi_fall};
      if (wr && paddr_i == `MPS_IRQ_MASK_OFS) begin
        mask_reg <= pwdata_i[`MPS_ST_W-1:0];
      end
      irq_o <= |(stat_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Strobe pins follow mode; expanded port 3 is a bus outside this block
  always @(posedge clock_i) begin
    if (reset_i) begin
      strobe_ctrl_pin_a_o <= 1'b1;
      strobe_ctrl_pin_a_oe_o <= 1'b0;
      strobe_ctrl_pin_b_o <= 1'b1;
      port1_o <= {P1_W{1'b0}};
      port1_oe_o <= {P1_W{1'b0}};
      port2_o <= {P2_W{1'b0}};
      port2_oe_o <= {P2_W{1'b0}};
      port3_o <= {P3_W{1'b0}};
      port3_oe_o <= {P3_W{1'b0}};
    end else begin
      strobe_ctrl_pin_a_oe_o <= mps_expanded(mode_reg);
      if (single) begin
        strobe_ctrl_pin_a_o <= 1'b1;
        strobe_ctrl_pin_b_o <= ~os3_req_reg;
      end else if (muxed) begin
        strobe_ctrl_pin_a_o <= (div_reg == 2'h0);
        strobe_ctrl_pin_b_o <= cpu_rw_i;
      end else begin
        strobe_ctrl_pin_a_o <= ~((cpu_addr_i >= `MPS_IOS_LO) && (cpu_addr_i <= `MPS_IOS_HI));
        strobe_ctrl_pin_b_o <= cpu_rw_i;
      end
      port1_o <= mps_drive(p1_dir_reg, p1_dat_reg);
      port1_oe_o <= p1_dir_reg;
      port2_o <= {p2_dat_reg[P2_W-1:2], compare_out_i & p2_dir_reg[1], p2_dat_reg[0]} & p2_dir_reg;
      port2_oe_o <= p2_dir_reg;
      port3_o <= single ? mps_drive(p3_dir_reg, p3_dat_reg) : {P3_W{1'b0}};
      port3_oe_o <= single ? p3_dir_reg : {P3_W{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; unmapped offsets answer with an error
  always @(posedge clock_i) begin
    if (reset_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (psel_i && !penable_i) begin
        case (paddr_i)
          `MPS_P1_DIR_OFS: prdata_o <= {24'h000000, p1_dir_reg};
          `MPS_P1_DATA_OFS: prdata_o <= {24'h000000, (p1_dir_reg & p1_dat_reg) | (~p1_dir_reg & port1_i)};
          `MPS_P2_DIR_OFS: prdata_o <= {27'h0, p2_dir_reg};
          `MPS_P2_DATA_OFS: prdata_o <= {27'h0, (p2_dir_reg & p2_dat_reg) | (~p2_dir_reg & port2_i)};
          `MPS_P3_DIR_OFS: prdata_o <= {24'h000000, p3_dir_reg};
          `MPS_P3_DATA_OFS: prdata_o <= {24'h000000, p3_latched_reg ? p3_latch_reg :
            ((p3_dir_reg & p3_dat_reg) | (~p3_dir_reg & port3_i))};
          `MPS_P3_CTRL_OFS: prdata_o <= {24'h000000, p3_flag_reg, p3_irq_en_reg, 1'b0, p3_oss_reg,
            p3_latch_en_reg, 3'h0};
          `MPS_CPU_OFS: prdata_o <= {30'h0, state_reg != ST_RUN, imask_reg};
          `MPS_IRQ_STAT_OFS: prdata_o <= {29'h0, stat_reg};
          `MPS_IRQ_MASK_OFS: prdata_o <= {29'h0, mask_reg};
          `MPS_MODE_OFS: prdata_o <= {29'h0, mode_reg};
          `MPS_VEC_OFS: prdata_o <= {16'h0000, vec_addr_o};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* mps_pins_properties.sv */
// Checker on the pin block ports: E clock, vectors, ports, output strobe.
// Assumes binding onto mps_pins; one clock, synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "mps_regs.vh"
module mps_pins_chk #(
  parameter P1_W = 8,
  parameter P2_W = 5,
  parameter P3_W = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic irq_o,
  input wire logic eclk_o,
  input wire logic instr_done_i,
  input wire logic compare_out_i,
  input wire logic vec_fetch_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic strobe_ctrl_pin_a_oe_o,
  input wire logic strobe_ctrl_pin_b_o,
  input wire logic [P1_W-1:0] port1_o,
  input wire logic [P1_W-1:0] port1_oe_o,
  input wire logic [P2_W-1:0] port2_o,
  input wire logic [P2_W-1:0] port2_oe_o,
  input wire logic [P3_W-1:0] port3_oe_o
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  // Pin A undriven for two clocks marks single-chip, so a pin B fall is a strobe
  sequence s_os3_fall;
    $fell(strobe_ctrl_pin_b_o) && !strobe_ctrl_pin_a_oe_o && $past(!strobe_ctrl_pin_a_oe_o);
  endsequence
  a_eclk_shape: assert property ($rose(eclk_o) |=> eclk_o ##1 !eclk_o[*2] ##1 eclk_o)
    else $error("E clock not two high two low");
  a_vec_cause: assert property (vec_fetch_o |-> $past(instr_done_i, 2))
    else $error("Vector fetch without instruction end");
  a_vec_pulse: assert property (vec_fetch_o |=> !vec_fetch_o)
    else $error("Vector fetch wider than one clock");
  a_vec_addr: assert property (vec_fetch_o |-> vec_addr_o inside {`MPS_VEC_NMI, `MPS_VEC_MASKABLE_REQUEST_ONE})
    else $error("Vector address unknown");
  a_reset_quiet: assert property ($past(reset_i) |-> !(|{port1_oe_o, port2_oe_o, port3_oe_o, irq_o}))
    else $error("Outputs driven after reset");
  a_port1_dir: assert property ((port1_o & ~port1_oe_o) == '0)
    else $error("Port 1 drives an input line");
  a_compare_out: assert property (port2_oe_o[1] && $past(port2_oe_o[1]) |-> port2_o[1] == $past(compare_out_i))
    else $error("Port 2 line 1 not from compare");
  a_os3_width: assert property (s_os3_fall |=> strobe_ctrl_pin_b_o)
    else $error("Output strobe not one clock");
  a_os3_cause: assert property (s_os3_fall |-> $past(psel_i && penable_i && paddr_i == `MPS_P3_DATA_OFS, 2))
    else $error("Output strobe without data access");
  c_nmi: cover property (vec_fetch_o && vec_addr_o == `MPS_VEC_NMI);
  c_maskable_request_one: cover property (vec_fetch_o && vec_addr_o == `MPS_VEC_MASKABLE_REQUEST_ONE);
  c_os3: cover property (s_os3_fall);
endmodule
bind mps_pins mps_pins_chk #(.P1_W(P1_W), .P2_W(P2_W), .P3_W(P3_W)) u_chk (.clock_i, .reset_i, .psel_i,
  .penable_i, .paddr_i, .pready_o, .irq_o, .eclk_o, .instr_done_i, .compare_out_i, .vec_fetch_o, .vec_addr_o,
  .strobe_ctrl_pin_a_oe_o, .strobe_ctrl_pin_b_o, .port1_o, .port1_oe_o, .port2_o, .port2_oe_o, .port3_oe_o);
`default_nettype wire

/* mps_ext_model.sv */
// Far side model: interrupt sources, port 3 input strobe and port 3 lines.
// Assumes the bench raises each go input for one clock.
`timescale 1ns/100ps
`default_nettype none
module mps_ext_model (
  input wire logic clock_i,
  input wire logic nmi_go_i,
  input wire logic is3_go_i,
  input wire logic maskable_request_one_lvl_i,
  input wire logic pa_i,
  input wire logic pa_oe_i,
  input wire logic [7:0] x3_i,
  input wire logic [7:0] d3_i,
  input wire logic [7:0] e3_i,
  output logic nmi_n_o,
  output logic maskable_request_one_n_o,
  output logic pa_o,
  output logic [7:0] p3_o
);
  logic [2:0] nmi_cnt = 3'h0;
  logic [2:0] is3_cnt = 3'h0;
  // Each request holds its line low a full E cycle, so no edge is missed
  always @(posedge clock_i) begin
    nmi_cnt <= nmi_go_i ? 3'h4 : nmi_cnt - {2'h0, nmi_cnt != 3'h0};
    is3_cnt <= is3_go_i ? 3'h4 : is3_cnt - {2'h0, is3_cnt != 3'h0};
  end
  // Pulled-up lines idle high; a pin the block drives reads back its level
  assign nmi_n_o = (nmi_cnt == 3'h0);
  assign maskable_request_one_n_o = !maskable_request_one_lvl_i;
  assign pa_o = pa_oe_i ? pa_i : (is3_cnt == 3'h0);
  assign p3_o = (d3_i & e3_i) | (x3_i & ~e3_i);
endmodule
`default_nettype wire

/* mps_pins_tb.sv */
// Self-checking bench for the pin block, driven over APB.
// Assumes the checker is bound in and the far side model answers.
`timescale 1ns/100ps
`default_nettype none
`include "mps_regs.vh"
module mps_pins_tb;
  logic clock_i, reset_i, psel_i, penable_i, pwrite_i, instr_done_i, cpu_rw_i, compare_out_i;
  logic pready_o, pslverr_o, irq_o, eclk_o, vec_fetch_o, nmi_n_i, maskable_request_one_n_i;
  logic strobe_ctrl_pin_a_i, strobe_ctrl_pin_a_o, strobe_ctrl_pin_a_oe_o, strobe_ctrl_pin_b_o;
  logic nmi_go, is3_go, maskable_request_one_lvl, pb_q, pe, pa, err;
  logic [7:0] paddr_i, port1_i, port1_o, port1_oe_o, port3_i, port3_o, port3_oe_o, ext3;
  logic [4:0] port2_i, port2_o, port2_oe_o, ext2;
  logic [15:0] vec_addr_o, cpu_addr_i, last_vec;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic [2:0] modes [4] = '{3'h2, 3'h3, 3'h5, 3'h7};
  logic [15:0] ios_a [4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
  int n_errors = 0, checked = 0, n_vec = 0, n_os3 = 0, ne, na;
  mps_pins u_dut (.*);
  mps_ext_model u_ext (.clock_i, .nmi_go_i(nmi_go), .is3_go_i(is3_go), .maskable_request_one_lvl_i(maskable_request_one_lvl),
    .pa_i(strobe_ctrl_pin_a_o), .pa_oe_i(strobe_ctrl_pin_a_oe_o), .x3_i(ext3), .d3_i(port3_o),
    .e3_i(port3_oe_o), .nmi_n_o(nmi_n_i), .maskable_request_one_n_o(maskable_request_one_n_i),
    .pa_o(strobe_ctrl_pin_a_i), .p3_o(port3_i));
  assign port1_i = port1_o;
  assign port2_i = ext2;
  always #20 clock_i = ~clock_i;
  // Count vector fetches and single-chip output strobes
  always @(posedge clock_i) begin
    pb_q <= strobe_ctrl_pin_b_o;
    if (vec_fetch_o === 1'b1) begin
      n_vec++;
      last_vec = vec_addr_o;
    end
    if (pb_q === 1'b1 && strobe_ctrl_pin_b_o === 1'b0 && strobe_ctrl_pin_a_oe_o === 1'b0)
      n_os3++;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clock_i);
    end
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n == 16) chk("pready", 1, 0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat[7:0]);
  endtask
  // Reset is held three E cycles; the mode code waits on port 2
  task automatic rst(input logic [2:0] m);
    ext2 <= {2'h0, m};
    reset_i <= 1'b1;
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic step();
    @(posedge clock_i);
    instr_done_i <= 1'b1;
    @(posedge clock_i);
    instr_done_i <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic report_and_stop();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cut a hang short; the sequence needs under three hundred clocks
  initial begin
    wt(20000);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {clock_i, psel_i, penable_i, pwrite_i, instr_done_i, compare_out_i, nmi_go, is3_go, maskable_request_one_lvl} = '0;
    {paddr_i, pwdata_i, cpu_addr_i} = '0;
    {reset_i, cpu_rw_i, ext2, ext3} = {2'b11, 5'h07, 8'h3C};
    foreach (modes[i]) begin
      rst(modes[i]);
      rd(`MPS_MODE_OFS, {5'h0, modes[i]});
      chk("pin_a_oe", modes[i] != 3'h7, strobe_ctrl_pin_a_oe_o);
      chk("port_oe", 0, {port1_oe_o, port2_oe_o, port3_oe_o});
      #1;
      {ne, na, pe, pa} = {64'h0, eclk_o, strobe_ctrl_pin_a_o};
      repeat (16) begin
        wt(1);
        #1;
        ne += int'(eclk_o && !pe);
        na += int'(strobe_ctrl_pin_a_o && !pa);
        {pe, pa} = {eclk_o, strobe_ctrl_pin_a_o};
      end
      chk("eclk", 4, ne);
      if (modes[i] < 3'h4) chk("addr_strobe", 4, na);
      if (modes[i] == 3'h5) begin
        foreach (ios_a[j]) begin
          cpu_addr_i <= ios_a[j];
          wt(3);
          chk("io_select", ios_a[j][15:8] != 8'h01, strobe_ctrl_pin_a_o);
        end
        cpu_rw_i <= 1'b0;
        wt(3);
        chk("rw", 0, strobe_ctrl_pin_b_o);
        cpu_rw_i <= 1'b1;
      end
      $display("mode %0d test done", modes[i]);
    end
    apb(1'b1, `MPS_P1_DIR_OFS, 32'h0F);
    apb(1'b1, `MPS_P1_DATA_OFS, 32'hA5);
    apb(1'b1, `MPS_P2_DIR_OFS, 32'h02);
    compare_out_i <= 1'b1;
    apb(1'b1, `MPS_P2_DATA_OFS, 32'h00);
    wt(2);
    chk("port1", 16'h0F05, {port1_oe_o, port1_o});
    chk("port2", 10'h042, {port2_oe_o, port2_o});
    rd(`MPS_P1_DIR_OFS, 8'h0F);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `MPS_P3_CTRL_OFS, k << 4);
      n_os3 = 0;
      apb(1'b1, `MPS_P3_DATA_OFS, 32'h00);
      rd(`MPS_P3_DATA_OFS, 8'h3C);
      wt(4);
      chk("os3_count", 1, n_os3);
    end
    apb(1'b1, `MPS_P3_DIR_OFS, 32'h0F);
    apb(1'b1, `MPS_P3_DATA_OFS, 32'hA5);
    wt(2);
    chk("port3", 16'h0F05, {port3_oe_o, port3_o});
    apb(1'b1, `MPS_P3_DIR_OFS, 32'h00);
    $display("port test done");
    apb(1'b1, `MPS_P3_CTRL_OFS, 32'h48);
    ext3 <= 8'h5A;
    is3_go <= 1'b1;
    wt(1);
    is3_go <= 1'b0;
    wt(8);
    ext3 <= 8'hC3;
    rd(`MPS_P3_CTRL_OFS, 8'hC8);
    rd(`MPS_IRQ_STAT_OFS, 8'h04);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, k == 2 ? `MPS_IRQ_STAT_OFS : `MPS_IRQ_MASK_OFS, k == 1 ? 32'h0 : 32'h4);
      wt(2);
      chk("irq_o", k == 0, irq_o);
    end
    rd(`MPS_P3_DATA_OFS, 8'h5A);
    rd(`MPS_P3_CTRL_OFS, 8'h48);
    $display("input strobe test done");
    nmi_go <= 1'b1;
    wt(1);
    nmi_go <= 1'b0;
    wt(8);
    chk("early_vec", 0, n_vec);
    step();
    chk("nmi_vec", 32'h1FFFC, {n_vec[15:0], last_vec});
    maskable_request_one_lvl <= 1'b1;
    step();
    chk("masked", 1, n_vec);
    apb(1'b1, `MPS_CPU_OFS, 32'h0);
    step();
    chk("maskable_request_one_vec", 32'h2FFF8, {n_vec[15:0], last_vec});
    maskable_request_one_lvl <= 1'b0;
    apb(1'b0, 8'h7C, 32'h0);
    chk("slverr", 1, err);
    apb(1'b1, `MPS_MODE_OFS, 32'h0);
    rd(`MPS_MODE_OFS, 8'h07);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
